// ---- rtl/jrs_pkg.sv ----
// jrs_pkg: constants, types and states of the jet recipe command sequencer
package jrs_pkg;
  localparam int CLK_HZ = 100_000_000; // system clock rate
  localparam int CLK_NS = 10; // system clock period in ns
  localparam int UNIT_NS = 100_000; // timer unit, 0.1 ms
  localparam int TICK_CYC = UNIT_NS / CLK_NS; // cycles per timer unit
  localparam int TICKS_PER_S = 10_000; // timer units per second
  localparam int BAUD_A = 115200; // serial rates
  localparam int BAUD_B = 57600;
  localparam int BAUD_C = 19200;
  localparam int BAUD_D = 9600;
  localparam int BAUD_E = 4800;
  localparam int DIV_A = CLK_HZ / BAUD_A; // cycles per serial bit
  localparam int DIV_B = CLK_HZ / BAUD_B;
  localparam int DIV_C = CLK_HZ / BAUD_C;
  localparam int DIV_D = CLK_HZ / BAUD_D;
  localparam int DIV_E = CLK_HZ / BAUD_E;
  localparam logic [2:0] BSEL_A = 3'h0; // rate select codes
  localparam logic [2:0] BSEL_B = 3'h1;
  localparam logic [2:0] BSEL_C = 3'h2;
  localparam logic [2:0] BSEL_D = 3'h3;
  localparam logic [1:0] PAR_NONE = 2'h0; // parity select codes
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [31:0] OFF_CFG = 32'h0000_0000; // serial setup register
  localparam logic [31:0] OFF_STAT = 32'h0000_0004; // status register
  localparam logic [31:0] CFG_RST = 32'h0000_0000; // 115200, no parity, 8 bits
  localparam logic [31:0] CFG_MASK = 32'h0000_0137; // writable cfg bits
  localparam int CFG_BAUD_LSB = 0;
  localparam int CFG_PAR_LSB = 4;
  localparam int CFG_LEN7_BIT = 8;
  localparam int ST_ACT_BIT = 0;
  localparam int ST_SEL_LSB = 4;
  localparam int ST_IDLE_LSB = 16;
  localparam logic [7:0] CH_SEMI = 8'h3B; // ascii codes
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_Z = 8'h5A;
  localparam logic [15:0] OP_TIMERS = 16'h5354; // set_timers_cmd
  localparam logic [15:0] OP_FIRST = 16'h534C; // first_drop_adjust_cmd
  localparam logic [15:0] OP_COUNT = 16'h4354; // count_format_cmd
  localparam logic [15:0] OP_SELECT = 16'h534D; // recipe_select_cmd
  localparam logic [15:0] OP_START = 16'h5347; // start_dispense_cmd
  localparam int N_ARGS = 7; // most values in one command
  localparam int N_REC = 6; // number of recipes
  localparam logic [3:0] ARGS_TIMERS = 4'h7; // value counts per command
  localparam logic [3:0] ARGS_FIRST = 4'h4;
  localparam logic [3:0] ARGS_COUNT = 4'h3;
  localparam logic [3:0] ARGS_SELECT = 4'h1;
  localparam logic [3:0] ARGS_START = 4'h0;
  localparam int A_ID = 0; // value positions
  localparam int A_REFILL = 1;
  localparam int A_DWELL = 6;
  localparam int A_PLUS = 1;
  localparam int A_PLUS2 = 2;
  localparam int A_IDLE = 3;
  localparam int A_KIND = 1;
  localparam int A_DROPS = 2;
  localparam logic KIND_PULSE = 1'b0;
  localparam logic KIND_LEVEL = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic [15:0] refill; // base refill, 0.1 ms units
    logic [15:0] dwell; // dwell, 0.1 ms units
    logic [15:0] plus; // normal first-drop extra
    logic [15:0] plus2; // long-idle first-drop extra
    logic [15:0] idle_s; // idle_threshold_s
    logic trigger_kind; // 0 pulse, 1 level
    logic [15:0] drops_per_trigger;
  } jrs_recipe_type;
  localparam jrs_recipe_type REC_RST = '{16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, KIND_PULSE, 16'h0001};
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} jrs_rx_type;
  typedef enum {P_OP1, P_OP2, P_ARG, P_SKIP} jrs_parse_type;
  typedef enum {J_IDLE, J_REFILL, J_DWELL} jrs_jet_type;
endpackage

// ---- rtl/jrs_sequencer.sv ----
// jrs_sequencer: serial command interpreter and jet drop sequencer
`timescale 1ns/1ps
module jrs_sequencer import jrs_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC, // cycles per 0.1 ms unit
  parameter int DIV_19K2 = DIV_C, // bit time at 19200
  parameter int DIV_9K6 = DIV_D, // bit time at 9600
  parameter int DIV_4K8 = DIV_E // bit time at 4800
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ser_rx_in, // serial command line
  input wire logic [N_REC-1:0] trig_in, // recipe triggers, active high
  output logic jet_fire_out, // high during refill
  output logic jet_active_n_out, // jet_active_n: high when idle
  input wire logic [31:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [31:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  default clocking dc @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  localparam logic [15:0] TICK_MAX = 16'(TICK_CYCLES - 1); // divider wrap
  localparam logic [13:0] SEC_MAX = 14'(TICKS_PER_S - 1); // last unit of a second, one less than units per second
  logic [15:0] tick_cnt; // 0.1 ms divider
  logic tick; // one-cycle unit pulse
  logic [13:0] sec_cnt; // units within a second
  logic [31:0] cfg; // serial setup
  logic [2:0] cfg_baud; // rate select
  logic [1:0] cfg_par; // parity select
  logic cfg_len7; // seven-bit characters
  logic [15:0] baud_div; // selected bit time
  jrs_rx_type rx_st; // receiver state
  logic [15:0] rx_cnt; // bit time counter
  logic [2:0] rx_bit; // data bit index
  logic [7:0] rx_sh; // data shifter
  logic rx_par; // running parity
  logic rx_valid; // one-cycle byte strobe
  logic [7:0] rx_data; // received byte
  jrs_parse_type p_st; // parser state
  logic [15:0] op; // two-letter opcode
  logic [15:0] args [N_ARGS]; // parsed values
  logic [3:0] nargs; // values seen
  logic [15:0] acc; // decimal accumulator
  logic have; // digits pending in acc
  logic exec; // command complete pulse
  jrs_recipe_type [N_REC-1:0] rec; // recipe table
  logic [2:0] sel; // selected recipe
  jrs_jet_type st; // jet state
  logic [2:0] cur; // recipe in use
  logic lvl; // level-triggered run
  logic [15:0] left; // pulse drops still due
  logic [15:0] cnt; // phase length in units
  logic [15:0] idle_s; // whole seconds idle
  logic [N_REC-1:0] trig_q; // trigger last cycle

  // unit tick and second divider
  assign tick = (tick_cnt == TICK_MAX);
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt <= 16'h0000;
      sec_cnt <= 14'h0000;
    end else begin
      tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
      if (st != J_IDLE) sec_cnt <= 14'h0000; // idle time restarts
      else if (tick) sec_cnt <= (sec_cnt == SEC_MAX) ? 14'h0000 : sec_cnt + 14'h0001;
    end
  end

  // serial setup decode
  assign cfg_baud = cfg[CFG_BAUD_LSB +: 3];
  assign cfg_par = cfg[CFG_PAR_LSB +: 2];
  assign cfg_len7 = cfg[CFG_LEN7_BIT];
  assign baud_div = (cfg_baud == BSEL_A) ? 16'(DIV_A) :
                    (cfg_baud == BSEL_B) ? 16'(DIV_B) :
                    (cfg_baud == BSEL_C) ? 16'(DIV_19K2) :
                    (cfg_baud == BSEL_D) ? 16'(DIV_9K6) : 16'(DIV_4K8);

  // serial receiver, samples mid-bit
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_st <= RX_IDLE;
      rx_cnt <= 16'h0000;
      rx_bit <= 3'h0;
      rx_sh <= 8'h00;
      rx_par <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      if (rx_st == RX_IDLE) begin
        if (!ser_rx_in) begin // start edge
          rx_cnt <= baud_div >> 1;
          rx_st <= RX_START;
        end
      end else if (rx_cnt != 16'h0000) begin
        rx_cnt <= rx_cnt - 16'h0001;
      end else begin
        rx_cnt <= baud_div - 16'h0001; // zero edge counts, so one bit is baud_div cycles
        case (rx_st)
          RX_START: begin // false start returns to idle
            rx_st <= ser_rx_in ? RX_IDLE : RX_DATA;
            rx_bit <= 3'h0;
            rx_par <= 1'b0;
          end
          RX_DATA: begin
            rx_sh <= {ser_rx_in, rx_sh[7:1]};
            rx_par <= rx_par ^ ser_rx_in;
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == (cfg_len7 ? 3'h6 : 3'h7))
              rx_st <= (cfg_par == PAR_NONE) ? RX_STOP : RX_PAR;
          end
          RX_PAR: begin
            rx_par <= rx_par ^ ser_rx_in;
            rx_st <= RX_STOP;
          end
          RX_STOP: begin // bad parity or framing drops byte
            rx_valid <= ser_rx_in && ((cfg_par == PAR_NONE) || (rx_par == (cfg_par == PAR_ODD)));
            rx_data <= cfg_len7 ? {1'b0, rx_sh[7:1]} : rx_sh;
            rx_st <= RX_IDLE;
          end
          default: rx_st <= RX_IDLE;
        endcase
      end
    end
  end

  // character classes
  logic is_digit, is_sep, is_semi, is_letter;
  logic [15:0] acc_dig; // accumulator with new digit
  assign is_digit = (rx_data >= CH_0) && (rx_data <= CH_9);
  assign is_sep = (rx_data == CH_COMMA) || (rx_data == CH_SPACE);
  assign is_semi = (rx_data == CH_SEMI);
  assign is_letter = (rx_data >= CH_A) && (rx_data <= CH_Z);
  assign acc_dig = 16'(acc * 16'h000A) + {8'h00, rx_data - CH_0};

  // command parser
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      p_st <= P_OP1;
      op <= 16'h0000;
      nargs <= 4'h0;
      acc <= 16'h0000;
      have <= 1'b0;
      exec <= 1'b0;
      for (int i = 0; i < N_ARGS; i++) args[i] <= 16'h0000;
    end else begin
      exec <= 1'b0;
      if (rx_valid) begin
        case (p_st)
          P_OP1: if (is_letter) begin // stray bytes skipped
            op[15:8] <= rx_data;
            p_st <= P_OP2;
          end
          P_OP2: if (is_letter) begin
            op[7:0] <= rx_data;
            nargs <= 4'h0;
            acc <= 16'h0000;
            have <= 1'b0;
            p_st <= P_ARG;
          end else begin
            p_st <= is_semi ? P_OP1 : P_SKIP;
          end
          P_ARG: if (is_digit) begin
            acc <= acc_dig;
            have <= 1'b1;
          end else if (is_sep || is_semi) begin
            if (have) begin
              if (nargs < 4'(N_ARGS)) args[nargs[2:0]] <= acc;
              nargs <= nargs + 4'h1; // overlong lists fail count check
            end
            acc <= 16'h0000;
            have <= 1'b0;
            if (is_semi) begin
              exec <= 1'b1;
              p_st <= P_OP1;
            end
          end else begin
            p_st <= P_SKIP; // garbled value
          end
          P_SKIP: if (is_semi) p_st <= P_OP1;
          default: p_st <= P_OP1;
        endcase
      end
    end
  end

  exec_semi_a: assert property (
    exec |-> ($past(rx_valid) && $past(rx_data) == CH_SEMI))
    else $error("command ran without semicolon");

  // command decode
  logic id_ok, do_timers, do_first, do_count, do_select, do_start;
  logic [2:0] rid; // addressed recipe
  assign id_ok = (args[A_ID] < 16'(N_REC));
  assign rid = args[A_ID][2:0];
  assign do_timers = exec && op == OP_TIMERS && nargs == ARGS_TIMERS && id_ok;
  assign do_first = exec && op == OP_FIRST && nargs == ARGS_FIRST && id_ok;
  assign do_count = exec && op == OP_COUNT && nargs == ARGS_COUNT && id_ok;
  assign do_select = exec && op == OP_SELECT && nargs == ARGS_SELECT && id_ok;
  assign do_start = exec && op == OP_START && nargs == ARGS_START;

  // recipe table and selection, anything else is discarded
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rec <= {N_REC{REC_RST}};
      sel <= 3'h0;
    end else begin
      if (do_timers) begin // reserved values unchecked
        rec[rid].refill <= args[A_REFILL];
        rec[rid].dwell <= args[A_DWELL];
      end
      if (do_first) begin
        rec[rid].plus <= args[A_PLUS];
        rec[rid].plus2 <= args[A_PLUS2];
        rec[rid].idle_s <= args[A_IDLE];
      end
      if (do_count) begin
        rec[rid].trigger_kind <= args[A_KIND][0];
        rec[rid].drops_per_trigger <= args[A_DROPS];
      end
      if (do_select) sel <= rid;
    end
  end

  bad_cmd_a: assert property (
    (exec && !id_ok && op != OP_START) |=> ($stable(rec) && $stable(sel)))
    else $error("rejected command changed a recipe");
  select_a: assert property (
    do_select |=> (sel == $past(rid)))
    else $error("recipe select not taken");

  // trigger qualification: edge for pulse, level for level
  logic [N_REC-1:0] tr_go; // trigger wants a start
  logic tr_hit; // some trigger wants a start
  logic [2:0] tr_idx; // lowest such trigger
  for (genvar g = 0; g < N_REC; g++) begin : g_trig
    assign tr_go[g] = trig_in[g] &&
      ((rec[g].trigger_kind == KIND_LEVEL) || !trig_q[g]);
  end
  always_comb begin
    tr_hit = 1'b0;
    tr_idx = 3'h0;
    for (int i = N_REC - 1; i >= 0; i--) begin
      if (tr_go[i]) begin
        tr_hit = 1'b1;
        tr_idx = 3'(i);
      end
    end
  end

  // start selection and first-drop refill
  logic [2:0] new_idx; // recipe to start
  jrs_recipe_type nr, cr; // starting and running recipe
  logic new_lvl, long_idle, accept, ph_end, more;
  logic [15:0] first_cnt; // first refill length
  assign new_idx = tr_hit ? tr_idx : sel;
  assign nr = rec[new_idx];
  assign cr = rec[cur];
  assign new_lvl = tr_hit && (nr.trigger_kind == KIND_LEVEL);
  assign long_idle = (idle_s > nr.idle_s);
  assign first_cnt = nr.refill + (long_idle ? nr.plus2 : nr.plus);
  assign accept = (st == J_IDLE) && (tr_hit || do_start) &&
                  (new_lvl || nr.drops_per_trigger != 16'h0000);
  assign ph_end = tick && (cnt <= 16'h0001);
  assign more = lvl ? trig_in[cur] : (left > 16'h0001);

  // drop sequencer: refill then dwell per drop
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= J_IDLE;
      cur <= 3'h0;
      lvl <= 1'b0;
      left <= 16'h0000;
      cnt <= 16'h0000;
      jet_fire_out <= 1'b0;
      jet_active_n_out <= 1'b1;
    end else begin
      case (st)
        J_IDLE: if (accept) begin
          cur <= new_idx;
          lvl <= new_lvl;
          left <= new_lvl ? 16'h0000 : nr.drops_per_trigger;
          cnt <= first_cnt;
          st <= J_REFILL;
          jet_fire_out <= 1'b1;
          jet_active_n_out <= 1'b0;
        end
        J_REFILL: if (ph_end) begin
          cnt <= cr.dwell;
          st <= J_DWELL;
          jet_fire_out <= 1'b0;
        end else if (tick) begin
          cnt <= cnt - 16'h0001;
        end
        J_DWELL: if (ph_end) begin
          if (more) begin // later drops: base refill only
            cnt <= cr.refill;
            if (!lvl) left <= left - 16'h0001;
            st <= J_REFILL;
            jet_fire_out <= 1'b1;
          end else begin
            st <= J_IDLE;
            jet_active_n_out <= 1'b1;
          end
        end else if (tick) begin
          cnt <= cnt - 16'h0001;
        end
        default: st <= J_IDLE;
      endcase
    end
  end

  // idle time in seconds and trigger history
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idle_s <= 16'h0000;
      trig_q <= '0;
    end else begin
      trig_q <= trig_in;
      if (st != J_IDLE) idle_s <= 16'h0000;
      else if (tick && sec_cnt == SEC_MAX && idle_s != 16'hFFFF) idle_s <= idle_s + 16'h0001;
    end
  end

  busy_level_a: assert property (
    jet_active_n_out == (st == J_IDLE)) else $error("busy output wrong");
  busy_ignore_a: assert property (
    (st == J_REFILL && !ph_end) |=> (st == J_REFILL && cur == $past(cur)))
    else $error("trigger disturbed a running drop");
  first_extra_a: assert property (
    (accept && !long_idle) |=> (cnt == 16'($past(nr.refill) + $past(nr.plus))))
    else $error("first drop lacks normal extra");
  long_idle_a: assert property (
    (accept && long_idle) |=> (cnt == 16'($past(nr.refill) + $past(nr.plus2))))
    else $error("first drop lacks long-idle extra");
  later_plain_a: assert property (
    (st == J_DWELL && ph_end && more) |=> (st == J_REFILL && cnt == cr.refill))
    else $error("later drop refill wrong");
  pulse_count_a: assert property (
    (accept && !new_lvl) |=> (left == $past(nr.drops_per_trigger) && !lvl))
    else $error("burst count not loaded");
  level_count_a: assert property (
    (accept && new_lvl) |=> (left == 16'h0000 && lvl))
    else $error("level run used drop count");
  pulse_stop_a: assert property (
    (st == J_DWELL && ph_end && !lvl && left <= 16'h0001) |=> (st == J_IDLE))
    else $error("burst ran past its count");
  burst_c: cover property (accept && !new_lvl && nr.drops_per_trigger > 16'h0001);
  level_c: cover property (st == J_DWELL && ph_end && more && lvl);
  start_c: cover property (accept && !tr_hit);
  ignored_c: cover property (st != J_IDLE && tr_hit);

  // register slave
  logic [31:0] aw_addr, w_data, cfg_wr, rd_word, stat_word;
  logic [3:0] w_strb;
  logic rd_ok;
  always_comb begin
    cfg_wr = cfg;
    for (int b = 0; b < 4; b++) begin
      if (w_strb[b]) cfg_wr[8*b +: 8] = w_data[8*b +: 8];
    end
  end
  assign stat_word = (32'(idle_s) << ST_IDLE_LSB) | (32'(sel) << ST_SEL_LSB) |
                     (32'(st != J_IDLE) << ST_ACT_BIT);
  assign rd_ok = (s_axi_araddr_in == OFF_CFG) || (s_axi_araddr_in == OFF_STAT);
  assign rd_word = (s_axi_araddr_in == OFF_CFG) ? cfg :
                   (s_axi_araddr_in == OFF_STAT) ? stat_word : 32'h0000_0000;

  // write path: address and data in any order, then response
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg <= CFG_RST;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_addr <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      if (!s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out) begin
        s_axi_bvalid_out <= 1'b1;
        if (aw_addr == OFF_CFG) cfg <= cfg_wr & CFG_MASK;
        s_axi_bresp_out <= (aw_addr == OFF_CFG || aw_addr == OFF_STAT) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  // read path: one answer per address
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= rd_word;
      s_axi_rresp_out <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end
endmodule // jrs_sequencer

// ---- sim/jrs_host_model.sv ----
// jrs_host_model: host side serial transmitter that sends ascii commands
`timescale 1ns/1ps
module jrs_host_model #(
  parameter int BIT_CYC = 16 // cycles per serial bit
) (
  input wire logic clk_sys_in,
  output logic ser_tx_out // line idles high between characters
);
  int bit_cyc = BIT_CYC; // current bit time
  logic [1:0] par_mode = 2'h0; // 0 none, 1 even, 2 odd
  logic len7 = 1'b0; // seven data bits
  initial ser_tx_out = 1'b1;
  // line setup, follows the receiver's setup register
  task automatic set_mode(input int c, input logic [1:0] p, input logic l7);
    bit_cyc = c;
    par_mode = p;
    len7 = l7;
  endtask
  // one character: start bit, data bits lsb first, optional parity, stop bit
  task automatic send_byte(input logic [7:0] ch);
    logic [10:0] frame;
    logic [7:0] dat;
    int nb;
    int nt;
    nb = len7 ? 7 : 8;
    nt = nb + ((par_mode != 2'h0) ? 3 : 2);
    dat = len7 ? {1'b0, ch[6:0]} : ch;
    frame = '1;
    frame[0] = 1'b0;
    for (int i = 0; i < nb; i++) frame[i + 1] = dat[i];
    if (par_mode != 2'h0) frame[nb + 1] = (^dat) ^ (par_mode == 2'h2);
    for (int i = 0; i < nt; i++) begin
      @(posedge clk_sys_in);
      ser_tx_out <= frame[i];
      repeat (bit_cyc - 1) @(posedge clk_sys_in);
    end
  endtask
  // opcode, values and terminator are all part of the text
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++) begin
      send_byte(s[i]);
    end
  endtask
endmodule // jrs_host_model

// ---- sim/test_jet_recipe_command_sequencer.sv ----
// test_jet_recipe_command_sequencer: self-checking bench for jrs_sequencer
`timescale 1ns/1ps
module test_jet_recipe_command_sequencer import jrs_pkg::*;;
  typedef struct packed {logic [15:0] n; logic [15:0] u1; logic [15:0] u2;} jrs_burst_type;
  logic clk = 1'b0, rst_n = 1'b0, ser, fire, act_n, awr, wr, bv, arr, rv, busy = 1'b0;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [5:0] trig = '0; // recipe triggers
  logic [31:0] aa = '0, wd = '0, ra = '0, rd;
  logic [1:0] bresp, rresp;
  logic [15:0] d; // random drop count
  logic [3:0] ws = 4'hF; // write strobes
  int error_cnt = 0, cmp_count = 0, wid = 0, cnt = 0;
  jrs_burst_type exp_q[$], seen = '0; // expected bursts, burst being watched
  initial forever #5 clk = ~clk;
  jrs_sequencer #(.TICK_CYCLES(10), .DIV_19K2(24), .DIV_9K6(20), .DIV_4K8(16)) u_dut (
    .clk_sys_in(clk), .rst_n_in(rst_n), .ser_rx_in(ser), .trig_in(trig), .jet_fire_out(fire),
    .jet_active_n_out(act_n), .s_axi_awaddr_in(aa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(br), .s_axi_araddr_in(ra), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rr));
  jrs_host_model #(.BIT_CYC(16)) u_host (.clk_sys_in(clk), .ser_tx_out(ser));
  // verdict; a nonzero argument marks a wait that ran out
  task automatic tally_and_finish(input int late);
    error_cnt += late;
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [47:0] got, input logic [47:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  // axi4-lite write, address and data offered together
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s,
                        input logic [1:0] er);
    int n = 0;
    @(posedge clk);
    aa <= a;
    wd <= v;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 99);
    br <= 1'b0;
    if (bv !== 1'b1) tally_and_finish(1);
    check(48'(bresp), 48'(er), "write response");
  endtask
  // axi4-lite read of one word
  task automatic axi_rd(input logic [31:0] a, input logic [31:0] ev, input logic [1:0] er);
    int n = 0;
    @(posedge clk);
    ra <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 99);
    rr <= 1'b0;
    if (rv !== 1'b1) tally_and_finish(1);
    check(48'(rd), 48'(ev), "read data");
    check(48'(rresp), 48'(er), "read response");
  endtask
  // send text, then let the interpreter act
  task automatic cmd(input string s);
    u_host.send_str(s);
    repeat (20) @(posedge clk);
  endtask
  // one-cycle trigger pulse; an empty note means it must be ignored
  task automatic pulse(input int i, input jrs_burst_type e);
    if (e.n != 0) exp_q.push_back(e);
    @(posedge clk);
    trig[i] <= 1'b1;
    @(posedge clk);
    trig[i] <= 1'b0;
  endtask
  task automatic wait_done;
    for (int n = 0; exp_q.size() > 0; n++) begin
      if (n > 3000) tally_and_finish(1);
      @(posedge clk);
    end
  endtask
  // burst watcher: counts drops, refill widths in units, compares at idle
  initial begin
    forever begin
      @(posedge clk);
      if (fire === 1'b1) begin
        check(48'(act_n), 48'h0, "busy flag high while firing");
        wid++;
      end else if (wid > 0) begin
        if (cnt == 0) seen.u1 = 16'((wid + 9) / 10);
        else seen.u2 = 16'((wid + 5) / 10);
        cnt++;
        wid = 0;
      end
      if (act_n === 1'b1 && busy) begin
        seen.n = 16'(cnt);
        if (exp_q.size() == 0) check(seen, '0, "burst not expected");
        else check(seen, exp_q.pop_front(), "burst shape");
        cnt = 0;
        seen = '0;
      end
      busy = (act_n === 1'b0);
    end
  end
  // main sequence
  initial begin
    void'($urandom(32'hCE55));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    axi_rd(OFF_CFG, CFG_RST, RESP_OKAY);
    axi_rd(32'h0000_0040, 32'h0000_0000, RESP_SLVERR);
    axi_wr(32'h0000_0040, 32'h0000_0001, 4'hF, RESP_SLVERR);
    axi_wr(OFF_CFG, 32'h0000_0004, 4'hF, RESP_OKAY);
    axi_wr(OFF_CFG, 32'h0000_0001, 4'h0, RESP_OKAY);
    axi_rd(OFF_CFG, 32'h0000_0004, RESP_OKAY);
    cmd("ST 0,2,0,0,0,0,3;SL 0,4,6,20;CT 0,0,2;");
    pulse(0, '{16'h0002, 16'h0006, 16'h0002});
    repeat (30) @(posedge clk);
    pulse(0, '0);
    wait_done;
    cmd("CT 0,0,1");
    pulse(0, '{16'h0002, 16'h0006, 16'h0002});
    wait_done;
    cmd(";");
    pulse(0, '{16'h0001, 16'h0006, 16'h0000});
    wait_done;
    cmd("CT 7,0,3;XX 0;");
    pulse(0, '{16'h0001, 16'h0006, 16'h0000});
    wait_done;
    axi_wr(OFF_CFG, 32'h0000_0112, 4'hF, RESP_OKAY);
    u_host.set_mode(24, PAR_EVEN, 1'b1);
    cmd("CT 0,0,2;");
    pulse(0, '{16'h0002, 16'h0006, 16'h0002});
    wait_done;
    axi_wr(OFF_CFG, 32'h0000_0023, 4'hF, RESP_OKAY);
    u_host.set_mode(20, PAR_ODD, 1'b0);
    d = 16'($urandom_range(4, 2));
    cmd($sformatf("CT 0,0,%0d;ST 1,2,0,0,0,0,3;CT 1,1,5;", d));
    pulse(0, '{d, 16'h0006, 16'h0002});
    wait_done;
    exp_q.push_back('{16'h0005, 16'h0002, 16'h0002});
    cmd("SM 1;SG;");
    wait_done;
    axi_rd(OFF_STAT, 32'h0000_0010, RESP_OKAY);
    exp_q.push_back('{16'h0007, 16'h0002, 16'h0002});
    trig[1] <= 1'b1;
    for (int n = 0; !(cnt == 6 && wid > 0); n++) begin
      if (n > 3000) tally_and_finish(1);
      @(posedge clk);
    end
    trig[1] <= 1'b0;
    wait_done;
    tally_and_finish(0);
  end
endmodule // test_jet_recipe_command_sequencer
